// file: fsi_pkg.sv
// constants and types for the symbol injection control block
package fsi_pkg;

   // register indices; byte address is four times the index
   localparam logic [5:0] FSI_IDX_TSR    = 6'h04;
   localparam logic [5:0] FSI_IDX_THR    = 6'h05;
   localparam logic [5:0] FSI_IDX_SYMA   = 6'h06;
   localparam logic [5:0] FSI_IDX_SYMB   = 6'h07;
   localparam logic [5:0] FSI_IDX_STATUS = 6'h0F;

   // transmit_state_reg fields
   localparam int FSI_TXMODE_LSB = 0;
   localparam int FSI_IC_LO_BIT  = 3;
   localparam int FSI_IC_HI_BIT  = 4;
   localparam int FSI_SMOOTH_BIT = 5;
   localparam int FSI_PARITY_BIT = 6;
   localparam int FSI_RSVD_BIT   = 7;

   // reserved bit set, smoother on, transmit mode off
   localparam logic [7:0] FSI_TSR_RESET = 8'hA2;
   localparam logic [7:0] FSI_REG_RESET = 8'h00;

   localparam logic [9:0] FSI_JK_PAIR = 10'h311;

   // symbol-pair timing
   localparam int         FSI_CLK_NS      = 8;
   localparam int         FSI_PAIR_NS     = 80;
   localparam int         FSI_PAIR_CYC    = FSI_PAIR_NS / FSI_CLK_NS;
   localparam logic [3:0] FSI_PHASE_LAST  = 4'(FSI_PAIR_CYC - 1);

   typedef enum logic [1:0] {
      FSI_INJ_NONE,
      FSI_INJ_ONESHOT,
      FSI_INJ_PERIODIC,
      FSI_INJ_CONTINUOUS
   } fsi_inj_mode_e;

   typedef struct packed {
      logic [7:0]  tsr;
      logic [7:0]  thr;
      logic [7:0]  sym_a;
      logic [7:0]  sym_b;
      logic [7:0]  cnt;
      logic        armed;
      logic [3:0]  phase;
      logic [9:0]  shift;
      logic [9:0]  pair_out;
      logic        inject;
      logic        par_err;
      logic [7:0]  smooth_cnt;
      logic        smooth_run;
      logic [31:0] rdata;
   } fsi_state_s;

   localparam fsi_state_s FSI_STATE_RESET = '{
      tsr: FSI_TSR_RESET, thr: FSI_REG_RESET, sym_a: FSI_REG_RESET,
      sym_b: FSI_REG_RESET, cnt: FSI_REG_RESET, armed: 1'b0, phase: 4'h0,
      shift: 10'h000, pair_out: 10'h000, inject: 1'b0, par_err: 1'b0,
      smooth_cnt: 8'h00, smooth_run: 1'b0, rdata: 32'h0000_0000};

endpackage

// file: fsi_inject_ctrl.sv
// symbol injection and transmit path control with apb register access
// Overview of operation
// - two-bit injection control field selects one of four injection modes
// - an active injection overrides smoother, repeat filter, encoder and transmit mode
// - mode 00 passes request data unchanged, nothing injected
// - mode 01 injects the programmed pair n pairs after a JK
// - one-shot with threshold zero replaces the JK pair itself
// - one-shot completion clears the low control bit by hardware
// - mode 10 replaces every n-th data pair with the injection pair
// - periodic with threshold zero replaces every data pair
// - periodic injection follows the counter only, no JK alignment
// - mode 11 replaces every data pair with the injection pair
// - smoother enable bit D5 switches the smoother on or off
// - bit D6 enables parity checking on request data
// - reserved top bit resets to one and stores writes with no effect
// - counter reloads from threshold at one or below and on threshold writes
// - counter is eight bits, decrements once per 80 ns symbol pair
// - counter runs only in one-shot or periodic, else holds
// - counter at one or below in periodic, or in one-shot once armed by a JK, substitutes the injection pair
// - counter is zero during reset
// - threshold register at index 05h is always readable and writable
// - smoother counter keeps counting once started, only a JK or clearing D5 interrupts it
// - reset gives transmit mode off, smoother on, injection and parity bits clear
// - injected symbols are 5B code sent most significant bit first
//
// The APB register port is this design's own decision.
`timescale 1ns/1ns

module fsi_inject_ctrl
   import fsi_pkg::*;
(
   input  wire logic        CORE_CLK,          // 125 MHz core clock
   input  wire logic        RST,               // synchronous reset, active high
   input  wire logic        PSEL,              // apb select
   input  wire logic        PENABLE,           // apb access phase
   input  wire logic        PWRITE,            // apb write
   input  wire logic [7:0]  PADDR,             // apb byte address
   input  wire logic [31:0] PWDATA,            // apb write data
   output logic      [31:0] PRDATA,            // apb read data
   output logic             PREADY,            // apb ready, always high
   output logic             PSLVERR,           // apb error on unmapped address
   input  wire logic [9:0]  REQ_PAIR,          // request symbol pair, first symbol high
   input  wire logic        REQ_PARITY,        // odd parity over the request pair
   output logic             PAIR_TAKE,         // pulse: request pair taken this edge
   output logic [9:0]       TX_PAIR,           // last chosen outgoing pair
   output logic             TX_INJECT,         // chosen pair is injected, overrides tx mode
   output logic             TX_BIT,            // serial outgoing bit, msb first
   output logic             PARITY_ERR,        // pulse: request parity mismatch
   output logic             SMOOTHER_ON,       // smoother enable
   output logic             REQUEST_PARITY_ON, // request parity check enable
   output logic [2:0]       TX_MODE_SELECT     // transmit mode for the line state generator
);

   fsi_state_s s_r;
   fsi_state_s s_nxt;

   logic          pair_edge;
   logic          wr;
   logic          setup;
   logic [5:0]    idx;
   logic          mapped;
   logic          jk;
   logic          inj;
   logic          shot_done;
   fsi_inj_mode_e mode;

   assign pair_edge = (s_r.phase == FSI_PHASE_LAST);
   assign wr        = PSEL & PENABLE & PWRITE;
   assign setup     = PSEL & ~PENABLE;
   assign idx       = PADDR[7:2];
   assign mapped    = (PADDR[1:0] == 2'b00) &&
                      (idx == FSI_IDX_TSR || idx == FSI_IDX_THR || idx == FSI_IDX_SYMA ||
                       idx == FSI_IDX_SYMB || idx == FSI_IDX_STATUS);
   assign jk        = (REQ_PAIR == FSI_JK_PAIR);
   assign mode      = fsi_inj_mode_e'(s_r.tsr[FSI_IC_HI_BIT:FSI_IC_LO_BIT]);

   always_comb begin
      s_nxt     = s_r;
      inj       = 1'b0;
      shot_done = 1'b0;
      s_nxt.par_err = 1'b0;
      s_nxt.phase   = pair_edge ? 4'h0 : 4'(s_r.phase + 4'h1);
      s_nxt.shift   = {s_r.shift[8:0], 1'b0};

      // all stream decisions on the pair boundary only
      if (pair_edge) begin
         unique case (mode)
            FSI_INJ_NONE: begin
               s_nxt.armed = 1'b0;
            end
            FSI_INJ_ONESHOT: begin
               if (!s_r.armed) begin
                  if (jk) begin
                     if (s_r.thr == 8'h00) begin
                        inj       = 1'b1;
                        shot_done = 1'b1;
                     end else begin
                        s_nxt.cnt   = s_r.thr;
                        s_nxt.armed = 1'b1;
                     end
                  end
               end else if (s_r.cnt <= 8'h01) begin
                  inj         = 1'b1;
                  shot_done   = 1'b1;
                  s_nxt.armed = 1'b0;
                  s_nxt.cnt   = s_r.thr;
               end else begin
                  s_nxt.cnt = 8'(s_r.cnt - 8'h01);
               end
            end
            FSI_INJ_PERIODIC: begin
               // free running; a JK does not restart the count
               s_nxt.armed = 1'b0;
               if (s_r.cnt <= 8'h01) begin
                  inj       = 1'b1;
                  s_nxt.cnt = s_r.thr;
               end else begin
                  s_nxt.cnt = 8'(s_r.cnt - 8'h01);
               end
            end
            FSI_INJ_CONTINUOUS: begin
               s_nxt.armed = 1'b0;
               inj         = 1'b1;
            end
         endcase
         if (shot_done)
            s_nxt.tsr[FSI_IC_LO_BIT] = 1'b0;
         // injection wins over everything downstream
         s_nxt.pair_out = inj ? {s_r.sym_a[4:0], s_r.sym_b[4:0]} : REQ_PAIR;
         s_nxt.inject   = inj;
         s_nxt.shift    = s_nxt.pair_out;
         if (s_r.tsr[FSI_PARITY_BIT] && !(^{REQ_PAIR, REQ_PARITY}))
            s_nxt.par_err = 1'b1;
         // smoother counter ignores symbol content except JK
         if (!s_r.tsr[FSI_SMOOTH_BIT]) begin
            s_nxt.smooth_run = 1'b0;
            s_nxt.smooth_cnt = 8'h00;
         end else if (jk) begin
            s_nxt.smooth_run = 1'b1;
            s_nxt.smooth_cnt = 8'h00;
         end else if (s_r.smooth_run) begin
            s_nxt.smooth_cnt = 8'(s_r.smooth_cnt + 8'h01);
         end
      end

      // software writes land after the stream logic, so a write beats the auto clear
      if (wr) begin
         unique case (idx)
            FSI_IDX_TSR:  s_nxt.tsr = PWDATA[7:0];
            FSI_IDX_THR: begin
               s_nxt.thr = PWDATA[7:0];
               s_nxt.cnt = PWDATA[7:0];
            end
            FSI_IDX_SYMA: s_nxt.sym_a = PWDATA[7:0];
            FSI_IDX_SYMB: s_nxt.sym_b = PWDATA[7:0];
            default: ;
         endcase
      end

      // read data captured in the setup phase, so it stands in the access phase
      if (setup) begin
         unique case (idx)
            FSI_IDX_TSR:    s_nxt.rdata = {24'h000000, s_r.tsr};
            FSI_IDX_THR:    s_nxt.rdata = {24'h000000, s_r.thr};
            FSI_IDX_SYMA:   s_nxt.rdata = {24'h000000, s_r.sym_a};
            FSI_IDX_SYMB:   s_nxt.rdata = {24'h000000, s_r.sym_b};
            FSI_IDX_STATUS: s_nxt.rdata = {15'h0000, s_r.armed, s_r.smooth_cnt, s_r.cnt};
            default:        s_nxt.rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST)
         s_r <= FSI_STATE_RESET;
      else
         s_r <= s_nxt;
   end

   assign PRDATA            = s_r.rdata;
   assign PREADY            = 1'b1;
   assign PSLVERR           = PSEL & PENABLE & ~mapped;
   assign PAIR_TAKE         = pair_edge;
   assign TX_PAIR           = s_r.pair_out;
   assign TX_INJECT         = s_r.inject;
   assign TX_BIT            = s_r.shift[9];
   assign PARITY_ERR        = s_r.par_err;
   assign SMOOTHER_ON       = s_r.tsr[FSI_SMOOTH_BIT];
   assign REQUEST_PARITY_ON = s_r.tsr[FSI_PARITY_BIT];
   assign TX_MODE_SELECT    = s_r.tsr[FSI_TXMODE_LSB +: 3];

endmodule

// file: fsi_inject_ctrl_properties.sv
// assertions for the symbol injection control block
`timescale 1ns/1ns
module fsi_props
   import fsi_pkg::*;
(
   input wire logic        CORE_CLK,          // clock
   input wire logic        RST,               // reset
   input wire logic        PSEL,              // apb select
   input wire logic        PENABLE,           // apb access
   input wire logic        PWRITE,            // apb write
   input wire logic [7:0]  PADDR,             // apb address
   input wire logic [31:0] PWDATA,            // apb data
   input wire logic        PSLVERR,           // apb error
   input wire logic [9:0]  REQ_PAIR,          // pair in
   input wire logic        REQ_PARITY,        // parity in
   input wire logic        PAIR_TAKE,         // pair edge
   input wire logic [9:0]  TX_PAIR,           // pair out
   input wire logic        TX_INJECT,         // injected
   input wire logic        TX_BIT,            // serial out
   input wire logic        PARITY_ERR,        // parity fault
   input wire logic        SMOOTHER_ON,       // ctrl bit
   input wire logic        REQUEST_PARITY_ON, // ctrl bit
   input wire logic [2:0]  TX_MODE_SELECT     // ctrl bits
);
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (RST);
   wire       ctrl_wr = PSEL && PENABLE && PWRITE && PADDR == 8'h10;
   wire       mapped  = PADDR inside {8'h10, 8'h14, 8'h18, 8'h1C, 8'h3C};
   wire [7:0] ctl_in  = PWDATA[7:0] & 8'h67;
   wire [7:0] ctl_out = {1'b0, REQUEST_PARITY_ON, SMOOTHER_ON, 2'b00, TX_MODE_SELECT};
   property p_period; PAIR_TAKE |=> !PAIR_TAKE [*8] ##1 !PAIR_TAKE ##1 PAIR_TAKE; endproperty
   a_period: assert property (p_period) else $error("pair spacing wrong");
   property p_hold; !PAIR_TAKE |=> $stable(TX_PAIR) && $stable(TX_INJECT); endproperty
   a_hold: assert property (p_hold) else $error("pair changed mid period");
   property p_pass; PAIR_TAKE |=> TX_INJECT || TX_PAIR == $past(REQ_PAIR); endproperty
   a_pass: assert property (p_pass) else $error("pair not passed");
   property p_serial;
      PAIR_TAKE |=> TX_BIT == TX_PAIR[9] ##1 TX_BIT == TX_PAIR[8] ##8 TX_BIT == TX_PAIR[0];
   endproperty
   a_serial: assert property (p_serial) else $error("serial order wrong");
   property p_ctrl; ctrl_wr |=> ctl_out == $past(ctl_in); endproperty
   a_ctrl: assert property (p_ctrl) else $error("ctrl outputs wrong");
   property p_rst; $fell(RST) |-> ctl_out == 8'h22 && !TX_INJECT; endproperty
   a_rst: assert property (p_rst) else $error("reset state wrong");
   property p_par_off; PAIR_TAKE && !REQUEST_PARITY_ON |=> !PARITY_ERR; endproperty
   a_par_off: assert property (p_par_off) else $error("parity flagged while off");
   property p_par_on;
      PAIR_TAKE && REQUEST_PARITY_ON && !(^{REQ_PAIR, REQ_PARITY}) |=> PARITY_ERR;
   endproperty
   a_par_on: assert property (p_par_on) else $error("parity fault missed");
   property p_slverr; PSEL && PENABLE |-> PSLVERR == !mapped; endproperty
   a_slverr: assert property (p_slverr) else $error("bus error wrong");
endmodule

bind fsi_inject_ctrl fsi_props u_props (
   .CORE_CLK          (CORE_CLK),
   .RST               (RST),
   .PSEL              (PSEL),
   .PENABLE           (PENABLE),
   .PWRITE            (PWRITE),
   .PADDR             (PADDR),
   .PWDATA            (PWDATA),
   .PSLVERR           (PSLVERR),
   .REQ_PAIR          (REQ_PAIR),
   .REQ_PARITY        (REQ_PARITY),
   .PAIR_TAKE         (PAIR_TAKE),
   .TX_PAIR           (TX_PAIR),
   .TX_INJECT         (TX_INJECT),
   .TX_BIT            (TX_BIT),
   .PARITY_ERR        (PARITY_ERR),
   .SMOOTHER_ON       (SMOOTHER_ON),
   .REQUEST_PARITY_ON (REQUEST_PARITY_ON),
   .TX_MODE_SELECT    (TX_MODE_SELECT)
);

// file: fsi_mac_model.sv
// request pair source standing in for the mac side
`timescale 1ns/1ns
module fsi_mac_model
   import fsi_pkg::*;
(
   input  wire logic       clk,      // core clock
   input  wire logic       rst,      // sync reset
   input  wire logic       take,     // pair taken
   input  wire logic       send_jk,  // present a jk pair
   input  wire logic       bad_par,  // corrupt parity
   output logic      [9:0] req_pair, // pair out
   output logic            req_par   // odd parity
);
   logic [7:0] seq_r;
   always_ff @(posedge clk) begin
      if (rst)
         seq_r <= 8'h00;
      else if (take)
         seq_r <= seq_r + 8'h01;
   end
   // top bits clear so data never mimics a jk or the injected pair
   assign req_pair = send_jk ? FSI_JK_PAIR : {2'b00, seq_r};
   assign req_par  = ~(^req_pair) ^ bad_par;
endmodule

// file: tb_fsi_inject_ctrl.sv
// self-checking bench for the symbol injection control block
`timescale 1ns/1ns
module tb_fsi_inject_ctrl;
   import fsi_pkg::*;
   localparam logic [9:0] INJ = 10'h2AA;
   logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, jk = 0, bad = 0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [9:0]  req_pair, tx_pair, got, sent;
   logic        req_par, pready, pslverr, perr, take, tx_inj, inj, err;
   logic        smooth_on, par_on, tx_bit;
   logic [2:0]  tx_mode;
   int          fails = 0, compares = 0, n;
   always #4 clk = ~clk;
   fsi_inject_ctrl uut (.CORE_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .REQ_PAIR(req_pair), .REQ_PARITY(req_par), .PAIR_TAKE(take), .TX_PAIR(tx_pair),
      .TX_INJECT(tx_inj), .TX_BIT(tx_bit), .PARITY_ERR(perr), .SMOOTHER_ON(smooth_on),
      .REQUEST_PARITY_ON(par_on), .TX_MODE_SELECT(tx_mode));
   fsi_mac_model mac (.clk(clk), .rst(rst), .take(take), .send_jk(jk), .bad_par(bad),
      .req_pair(req_pair), .req_par(req_par));
   task automatic stop_test;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         fails++;
         $display("mismatch at %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      {psel, pen, pwr, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge clk);
      pen <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge clk);
         if (pready === 1'b1)
            break;
      end
      rd = prdata;
      err = pslverr;
      {psel, pen} <= 2'b00;
      if (n == 20) begin
         fails++;
         stop_test();
      end
   endtask
   task automatic pair;
      for (n = 0; n < 30; n++) begin
         @(negedge clk);
         if (take === 1'b1)
            break;
      end
      if (n == 30) begin
         fails++;
         stop_test();
      end else begin
         sent = req_pair;
         @(posedge clk);
         {jk, bad} <= 2'b00;
         @(negedge clk);
         got = tx_pair;
         inj = tx_inj;
      end
   endtask
   task automatic expect_pair(input logic e);
      pair();
      chk(32'({inj, got}), 32'({e, e ? INJ : sent}));
   endtask
   task automatic t_regs;
      chk(32'({par_on, smooth_on, tx_mode}), 32'h0A);
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, 8'(8'h10 + 4 * i), 32'h0);
         chk(rd, i == 0 ? 32'hA2 : 32'h0);
      end
      apb(1'b0, 8'h3C, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 8'h20, 32'h0);
      chk({err, rd[30:0]}, 32'h8000_0000);
      apb(1'b1, 8'h14, 32'h5A);
      apb(1'b0, 8'h14, 32'h0);
      chk(rd, 32'h5A);
      pair();
      apb(1'b0, 8'h3C, 32'h0);
      chk(rd & 32'hFF, 32'h5A);
      apb(1'b1, 8'h10, 32'h22);
      apb(1'b0, 8'h10, 32'h0);
      chk(rd, 32'h22);
      $display("t_regs done");
   endtask
   task automatic t_modes;
      int cnt;
      logic [9:0] ser;
      apb(1'b1, 8'h18, 32'h15);
      apb(1'b1, 8'h1C, 32'h0A);
      apb(1'b1, 8'h10, 32'hA2);
      pair();
      expect_pair(1'b0);
      apb(1'b1, 8'h10, 32'hBA);
      pair();
      for (int i = 0; i < 3; i++)
         expect_pair(1'b1);
      // serial bits of the pair just taken, one per cycle, msb first
      ser = 10'h000;
      for (int i = 0; i < 10; i++) begin
         ser = {ser[8:0], tx_bit};
         @(negedge clk);
      end
      chk(32'(ser), 32'(INJ));
      apb(1'b1, 8'h14, 32'h03);
      apb(1'b1, 8'h10, 32'hB2);
      pair();
      cnt = 0;
      for (int i = 0; i < 9; i++) begin
         pair();
         cnt += int'(inj === 1'b1);
      end
      chk(32'(cnt), 32'h3);
      apb(1'b1, 8'h14, 32'h00);
      pair();
      for (int i = 0; i < 3; i++)
         expect_pair(1'b1);
      $display("t_modes done");
   endtask
   task automatic t_oneshot(input logic [7:0] thr);
      apb(1'b1, 8'h14, 32'(thr));
      apb(1'b1, 8'h10, 32'hAA);
      pair();
      @(posedge clk);
      jk <= 1'b1;
      for (int i = 0; i < 4; i++)
         expect_pair(i == int'(thr));
      apb(1'b0, 8'h10, 32'h0);
      chk(rd, 32'hA2);
      // jk restarted the smoother count three pairs ago; counter back at threshold
      apb(1'b0, 8'h3C, 32'h0);
      chk(rd, 32'h0000_0300 | 32'(thr));
      $display("t_oneshot done");
   endtask
   task automatic t_parity;
      apb(1'b1, 8'h10, 32'hE2);
      pair();
      chk(32'({par_on, smooth_on, tx_mode}), 32'h1A);
      @(posedge clk);
      bad <= 1'b1;
      pair();
      chk(32'(perr), 32'h1);
      pair();
      chk(32'(perr), 32'h0);
      // smoother off: its running count must be cleared at the next pair
      apb(1'b1, 8'h10, 32'h42);
      pair();
      chk(32'({par_on, smooth_on, tx_mode}), 32'h12);
      apb(1'b0, 8'h3C, 32'h0);
      chk(rd, 32'h0);
      $display("t_parity done");
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_modes();
      t_oneshot(8'h02);
      t_oneshot(8'h00);
      t_parity();
      stop_test();
   end
endmodule
